// file: rtl/lss_loop_setting_store.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - out-of-range write sets error flag and number, old value kept
// - accepted values go to working RAM only, not to saved memory
// - save bit rising 0 to 1 copies loop settings; held level does nothing
// - restore switch on: saved settings reloaded after every reset
// - burnout threshold 0..500 tenths; 0 forces alarm off, 500 on
// - alarm kind codes 0..9 decoded per digit, default 0
// - set point range follows sensor input type, default 0
// - heater current above 55.0 A reads -13,108, else 0..550 tenths
// - output level shows driven level; on/off mode reads 1000 or 0
// - a save writes only the loop whose save bit rose
// - gain band, reset and rate times locked while tuning done flag set
module lss_loop_setting_store (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // straps, taken once after reset
  input wire logic sensorPlatinum,
  input wire logic [3:0] sensorType,
  input wire logic tempFahrenheit,
  input wire logic autoRestoreSwitch,
  // loop measurements
  input wire logic signed [15:0] measuredTemperature [lss_pkg::LOOPS],
  input wire logic [15:0] measuredHeaterCurrent [lss_pkg::LOOPS],
  input wire logic [15:0] driveLevel [lss_pkg::LOOPS],
  input wire logic [lss_pkg::LOOPS-1:0] outputOn,
  input wire logic onoffMode,
  input wire logic [lss_pkg::LOOPS-1:0] tuningDoneFlag,
  // settings in use
  output logic signed [15:0] loopSetting [lss_pkg::LOOPS][lss_pkg::NSET],
  output lss_pkg::lss_alarm_t alarmKindSelect [lss_pkg::LOOPS][2],
  output logic [lss_pkg::LOOPS-1:0] heaterBreakAlarm,
  output logic irq
);
  import lss_pkg::*;

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  lss_state_t state_ff;
  logic [4:0] cnt_ff;
  logic saveLoop_ff;
  logic [1:0] saveBits_ff, saveBitsPrev_ff, pendSave_ff;
  logic strapDone_ff, plat_ff, fahr_ff;
  logic [3:0] kind_ff;
  logic signed [15:0] wram_ff [LOOPS][NSET];
  logic [15:0] alarmKind_ff;
  logic errFlag_ff;
  logic [7:0] errNum_ff;
  logic [IRQ_W-1:0] irqStat_ff, irqMask_ff;
  logic [15:0] tempMon_ff [LOOPS], curMon_ff [LOOPS], levelMon_ff [LOOPS];
  logic [LOOPS-1:0] breakAlarm_ff;
  logic [31:0] prdata_ff;
  lss_nv_if nv ();

  lss_nv_store u_nv (
    .sys_clk(sys_clk),
    .reset(reset),
    .nv(nv)
  );

  // integer range test on the raw written value
  function automatic logic fits(input logic signed [31:0] v, input logic signed [31:0] lo,
      input logic signed [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // ----------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------
  logic access, setWr, setHit, wrLoop, isPid, valOk, kindWr, loadWr, saveDone, loadDone;
  logic [3:0] wrIdx;
  logic [4:0] loadLin;
  logic signed [31:0] wrVal, lo, hi;
  logic [1:0] saveRise;
  logic [7:0] errCode;
  logic [31:0] rdMux;
  logic mapped;

  assign access = psel && penable && pready;
  assign wrLoop = paddr[6];
  assign wrIdx = paddr[5:2];
  assign setHit = (paddr < ALARM_KIND_OFS) && (wrIdx < 4'(NSET)) && (paddr[1:0] == 2'b00);
  assign setWr = access && pwrite && setHit;
  assign kindWr = access && pwrite && (paddr == ALARM_KIND_OFS);
  assign wrVal = 32'(signed'(pwdata[15:0]));
  assign isPid = wrIdx >= 4'(GAIN_BAND_SETTING);
  assign errCode = {2'b00, 1'b0, wrLoop, wrIdx} + 8'h01;

  // set point limits follow the sensor strap, others are fixed
  always_comb begin
    lo = 32'(SET_MIN[wrIdx < 4'(NSET) ? wrIdx : 4'h0]);
    hi = 32'(SET_MAX[wrIdx < 4'(NSET) ? wrIdx : 4'h0]);
    if (wrIdx == 4'(LOOP_TARGET_TEMPERATURE)) begin
      lo = lss_sp_limit(plat_ff, kind_ff, fahr_ff, 1'b0);
      hi = lss_sp_limit(plat_ff, kind_ff, fahr_ff, 1'b1);
    end
  end
  assign valOk = fits(wrVal, lo, hi);

  // restore walk: word at cnt-1 arrives from the array this cycle
  assign loadLin = cnt_ff - 5'h01;
  assign loadWr = (state_ff == ST_LOAD) && (cnt_ff != 5'h00);
  assign saveDone = (state_ff == ST_SAVE) && (cnt_ff == 5'(NSET - 1));
  assign loadDone = (state_ff == ST_LOAD) && (cnt_ff == 5'(NV_WORDS));

  // ----------------------------------------------------------
  // working ram
  // ----------------------------------------------------------
  // restore has the bus stalled, so the two writers never meet
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int l = 0; l < LOOPS; l++) begin
        for (int i = 0; i < NSET; i++) begin
          wram_ff[l][i] <= SET_DFLT[i];
        end
      end
    end else if (loadWr) begin
      if (loadLin >= 5'(NSET)) begin
        wram_ff[1][4'(loadLin - 5'(NSET))] <= nv.rData;
      end else begin
        wram_ff[0][4'(loadLin)] <= nv.rData;
      end
    end else if (setWr && valOk && !(isPid && tuningDoneFlag[wrLoop])) begin
      wram_ff[wrLoop][wrIdx] <= pwdata[15:0];
    end
  end
  assign loopSetting = wram_ff;

  // alarm kind word, one decimal digit per loop alarm
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      alarmKind_ff <= 16'h0000;
    end else if (kindWr && (pwdata[31:16] == 16'h0000) && (pwdata[15:0] <= KIND_MAX)) begin
      alarmKind_ff <= pwdata[15:0];
    end
  end
  always_comb begin
    for (int l = 0; l < LOOPS; l++) begin
      for (int a = 0; a < 2; a++) begin
        alarmKindSelect[l][a] = lss_alarm_t'(4'((alarmKind_ff / (16'd10 ** (l * 2 + a)))
          % 16'd10));
      end
    end
  end

  // setting error flag and number; a new error beats the read clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      errFlag_ff <= 1'b0;
      errNum_ff <= 8'h00;
    end else if (setWr && !valOk) begin
      errFlag_ff <= 1'b1;
      errNum_ff <= errCode;
    end else if (kindWr && !((pwdata[31:16] == 16'h0000) && (pwdata[15:0] <= KIND_MAX))) begin
      errFlag_ff <= 1'b1;
      errNum_ff <= ERR_KIND_NUM;
    end else if (access && !pwrite && (paddr == ERR_OFS)) begin
      errFlag_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // control bits, save edge and strap capture
  // ----------------------------------------------------------
  assign saveRise = saveBits_ff & ~saveBitsPrev_ff;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      saveBits_ff <= 2'b00;
      saveBitsPrev_ff <= 2'b00;
    end else begin
      saveBitsPrev_ff <= saveBits_ff;
      if (access && pwrite && (paddr == CTRL_OFS)) begin
        saveBits_ff <= pwdata[1:0];
      end
    end
  end

  // straps only take effect at a restart
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      strapDone_ff <= 1'b0;
      plat_ff <= 1'b0;
      kind_ff <= 4'h0;
      fahr_ff <= 1'b0;
    end else if (!strapDone_ff) begin
      strapDone_ff <= 1'b1;
      plat_ff <= sensorPlatinum;
      kind_ff <= sensorType;
      fahr_ff <= tempFahrenheit;
    end
  end

  // ----------------------------------------------------------
  // save and restore sequencer
  // ----------------------------------------------------------
  // a rise seen while busy waits in pendSave; the new rise beats the clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 5'h00;
      saveLoop_ff <= 1'b0;
      pendSave_ff <= 2'b00;
    end else begin
      pendSave_ff <= pendSave_ff | saveRise;
      unique case (state_ff)
        ST_IDLE: begin
          cnt_ff <= 5'h00;
          if (!strapDone_ff) begin
            if (autoRestoreSwitch) begin
              state_ff <= ST_LOAD;
            end
          end else if (pendSave_ff != 2'b00) begin
            state_ff <= ST_SAVE;
            saveLoop_ff <= !pendSave_ff[0];
            pendSave_ff <= (pendSave_ff & ~(pendSave_ff[0] ? 2'b01 : 2'b10)) | saveRise;
          end
        end
        ST_SAVE: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (saveDone) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_LOAD: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (loadDone) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // only the save state ever writes the array
  always_comb begin
    nv.wrEn = (state_ff == ST_SAVE);
    nv.addr = (state_ff == ST_SAVE) ? (saveLoop_ff ? 5'(NSET) : 5'h00) + cnt_ff : cnt_ff;
    nv.wData = wram_ff[saveLoop_ff][4'(cnt_ff)];
  end

  // ----------------------------------------------------------
  // monitors and burnout
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int l = 0; l < LOOPS; l++) begin
        tempMon_ff[l] <= 16'h0000;
        curMon_ff[l] <= 16'h0000;
        levelMon_ff[l] <= 16'h0000;
      end
      breakAlarm_ff <= 2'b00;
    end else begin
      for (int l = 0; l < LOOPS; l++) begin
        tempMon_ff[l] <= measuredTemperature[l];
        curMon_ff[l] <= (measuredHeaterCurrent[l] > CUR_LIMIT) ? CUR_OVERFLOW
          : measuredHeaterCurrent[l];
        levelMon_ff[l] <= onoffMode ? (outputOn[l] ? LEVEL_FULL : LEVEL_NONE)
          : driveLevel[l];
        if (wram_ff[l][LOOP_HEATER_BREAK_THRESHOLD] == BREAK_OFF) begin
          breakAlarm_ff[l] <= 1'b0;
        end else if (wram_ff[l][LOOP_HEATER_BREAK_THRESHOLD] == BREAK_ON) begin
          breakAlarm_ff[l] <= 1'b1;
        end else begin
          breakAlarm_ff[l] <= outputOn[l] && (signed'({1'b0, measuredHeaterCurrent[l]})
            < 17'(wram_ff[l][LOOP_HEATER_BREAK_THRESHOLD]));
        end
      end
    end
  end
  assign heaterBreakAlarm = breakAlarm_ff;

  // ----------------------------------------------------------
  // interrupts: events stick until the status read, set wins
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irqStat_ff <= '0;
      irqMask_ff <= '0;
    end else begin
      if (access && pwrite && (paddr == IRQ_MASK_OFS)) begin
        irqMask_ff <= pwdata[IRQ_W-1:0];
      end
      irqStat_ff <= ((access && !pwrite && (paddr == IRQ_STAT_OFS)) ? '0 : irqStat_ff)
        | {loadDone, saveDone, (setWr && !valOk)};
    end
  end
  assign irq = |(irqStat_ff & irqMask_ff);

  // ----------------------------------------------------------
  // read path, captured in the setup cycle
  // ----------------------------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    mapped = 1'b1;
    if (setHit) begin
      rdMux = {16'h0000, wram_ff[wrLoop][wrIdx]};
    end else begin
      unique case (paddr)
        ALARM_KIND_OFS: rdMux = {16'h0000, alarmKind_ff};
        CTRL_OFS: rdMux = {30'h0000_0000, saveBits_ff};
        ERR_OFS: rdMux = {15'h0000, state_ff != ST_IDLE, errNum_ff, 7'h00, errFlag_ff};
        IRQ_STAT_OFS: rdMux = {29'h0000_0000, irqStat_ff};
        IRQ_MASK_OFS: rdMux = {29'h0000_0000, irqMask_ff};
        MON_TEMP_OFS, MON_TEMP_OFS + 12'h004: rdMux = {16'h0000, tempMon_ff[paddr[2]]};
        MON_CUR_OFS, MON_CUR_OFS + 12'h004: rdMux = {16'h0000, curMon_ff[paddr[2]]};
        MON_LEVEL_OFS, MON_LEVEL_OFS + 12'h004: rdMux = {16'h0000, levelMon_ff[paddr[2]]};
        default: mapped = 1'b0;
      endcase
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_ff <= rdMux;
    end
  end
  assign prdata = prdata_ff;
  // restore holds the bus off so software never sees half-loaded values
  assign pready = penable && (state_ff != ST_LOAD) && strapDone_ff;
  assign pslverr = psel && penable && pready && !mapped;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic chkLoop_ff;
  logic [3:0] chkIdx_ff;
  logic signed [15:0] chkVal_ff;
  always_ff @(posedge sys_clk) begin
    chkLoop_ff <= wrLoop;
    chkIdx_ff <= (wrIdx < 4'(NSET)) ? wrIdx : 4'h0;
    chkVal_ff <= wram_ff[wrLoop][(wrIdx < 4'(NSET)) ? wrIdx : 4'h0];
  end
  sequence saveWalk;
    nv.wrEn[*8] ##1 nv.wrEn[*4] ##1 !nv.wrEn;
  endsequence
  bad_write_keep_a: assert property (setWr && !valOk |=> errFlag_ff &&
    wram_ff[chkLoop_ff][chkIdx_ff] == chkVal_ff) else $error("bad write changed value");
  err_number_a: assert property (setWr && !valOk |=> errNum_ff == $past(errCode))
    else $error("wrong setting error number");
  nv_save_only_a: assert property (nv.wrEn |-> state_ff == ST_SAVE)
    else $error("saved memory written outside save");
  save_walk_a: assert property ($rose(state_ff == ST_SAVE) |-> saveWalk)
    else $error("save did not write twelve words");
  held_bit_a: assert property (state_ff == ST_IDLE && strapDone_ff && pendSave_ff == 2'b00
    |=> state_ff != ST_SAVE) else $error("save started without rising bit");
  save_loop_a: assert property (nv.wrEn |-> (nv.addr >= 5'(NSET)) == saveLoop_ff)
    else $error("save touched other loop");
  restore_a: assert property (!strapDone_ff && autoRestoreSwitch |=>
    (state_ff == ST_LOAD)[*8] ##18 state_ff == ST_IDLE) else $error("restore walk wrong");
  break_force_a: assert property (wram_ff[0][LOOP_HEATER_BREAK_THRESHOLD] == BREAK_ON
    |=> heaterBreakAlarm[0]) else $error("burnout not forced on");
  pid_lock_a: assert property (setWr && isPid && tuningDoneFlag[wrLoop] |=>
    wram_ff[chkLoop_ff][chkIdx_ff] == chkVal_ff) else $error("locked constant written");
  cur_over_a: assert property (measuredHeaterCurrent[0] > CUR_LIMIT |=>
    curMon_ff[0] == CUR_OVERFLOW) else $error("current overflow not shown");
  level_onoff_a: assert property (onoffMode |=> levelMon_ff[1] ==
    ($past(outputOn[1]) ? LEVEL_FULL : LEVEL_NONE)) else $error("on/off level wrong");
endmodule // lss_loop_setting_store
`default_nettype wire

// file: rtl/lss_nv_if.sv
`timescale 1ns/100ps
`default_nettype none
// word port between the setting store and its non-volatile array
interface lss_nv_if;
  logic wrEn;
  logic [4:0] addr;
  logic [15:0] wData;
  logic [15:0] rData;
  logic [31:0] writeCount;
  modport ctrl (output wrEn, addr, wData, input rData, writeCount);
  modport store (input wrEn, addr, wData, output rData, writeCount);
endinterface // lss_nv_if
`default_nettype wire

// file: rtl/lss_nv_store.sv
`timescale 1ns/100ps
`default_nettype none
module lss_nv_store (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // word port
  lss_nv_if.store nv
);
  import lss_pkg::*;
  logic [15:0] mem [NV_WORDS];

  // saved image has no reset: it must outlive a restart for the restore walk
  always_ff @(posedge sys_clk) begin
    if (nv.wrEn) begin
      mem[nv.addr] <= nv.wData;
    end
  end

  // registered read, one cycle after the address
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      nv.rData <= 16'h0000;
    end else begin
      nv.rData <= mem[nv.addr];
    end
  end

  // wear counter, words written since the last reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      nv.writeCount <= 32'h0000_0000;
    end else if (nv.wrEn) begin
      nv.writeCount <= nv.writeCount + 32'h0000_0001;
    end
  end
endmodule // lss_nv_store
`default_nettype wire

// file: rtl/lss_pkg.sv
package lss_pkg;
  // ----------------------------------------------------------
  // sizes and register map
  // ----------------------------------------------------------
  localparam int LOOPS = 2;
  localparam int NSET = 12;
  localparam int NV_WORDS = LOOPS * NSET;
  localparam logic [11:0] LOOP_STRIDE_OFS = 12'h040;
  localparam logic [11:0] ALARM_KIND_OFS = 12'h080;
  localparam logic [11:0] CTRL_OFS = 12'h084;
  localparam logic [11:0] ERR_OFS = 12'h088;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h08C;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h090;
  localparam logic [11:0] MON_TEMP_OFS = 12'h0A0;
  localparam logic [11:0] MON_CUR_OFS = 12'h0A8;
  localparam logic [11:0] MON_LEVEL_OFS = 12'h0B0;
  // ----------------------------------------------------------
  // setting word indexes within a loop
  // ----------------------------------------------------------
  localparam int LOOP_TARGET_TEMPERATURE = 0;
  localparam int LOOP_HEATER_BREAK_THRESHOLD = 1;
  localparam int ALARM_ONE_DEADBAND = 2;
  localparam int ALARM_TWO_DEADBAND = 3;
  localparam int ALARM_ONE_LEVEL = 4;
  localparam int ALARM_TWO_LEVEL = 5;
  localparam int INPUT_OFFSET_SETTING = 6;
  localparam int OUTPUT_CYCLE_TIME = 7;
  localparam int ONOFF_DEADBAND = 8;
  localparam int GAIN_BAND_SETTING = 9;
  localparam int RESET_TIME_SETTING = 10;
  localparam int RATE_TIME_SETTING = 11;
  // limits and defaults, one-decimal values held as tenths
  localparam logic signed [15:0] SET_MIN [NSET] = '{0, 0, 0, 0, -999, -999, -999, 1, 0, 0,
    0, 0};
  localparam logic signed [15:0] SET_MAX [NSET] = '{0, 500, 9999, 9999, 9999, 9999, 9999,
    99, 9999, 9999, 9999, 9999};
  localparam logic signed [15:0] SET_DFLT [NSET] = '{0, 0, 0, 0, 0, 0, 0, 20, 8, 80, 233,
    40};
  localparam logic [15:0] KIND_MAX = 16'h270F;
  // ----------------------------------------------------------
  // monitors, burnout, status fields
  // ----------------------------------------------------------
  localparam logic [15:0] CUR_LIMIT = 16'h0226;
  localparam logic [15:0] CUR_OVERFLOW = 16'hCCCC;
  localparam logic [15:0] LEVEL_FULL = 16'h03E8;
  localparam logic [15:0] LEVEL_NONE = 16'h0000;
  localparam logic signed [15:0] BREAK_OFF = 16'sh0000;
  localparam logic signed [15:0] BREAK_ON = 16'sh01F4;
  localparam logic [7:0] ERR_KIND_NUM = 8'h40;
  localparam int IRQ_ERR = 0;
  localparam int IRQ_SAVE = 1;
  localparam int IRQ_LOAD = 2;
  localparam int IRQ_W = 3;
  localparam int ERR_NUM_LSB = 8;
  localparam int BUSY_BIT = 16;

  typedef enum logic [3:0] {AK_NONE, AK_UPPER_LOWER, AK_UPPER, AK_LOWER, AK_RANGE,
    AK_UPPER_LOWER_STBY, AK_UPPER_STBY, AK_LOWER_STBY, AK_ABS_UPPER, AK_ABS_LOWER
  } lss_alarm_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_LOAD} lss_state_t;

  // set point limits per sensor input type, tenths for one-decimal ranges
  function automatic logic signed [31:0] lss_sp_limit(input logic plat,
      input logic [3:0] kind, input logic fahr, input logic upper);
    logic signed [15:0] lo;
    logic signed [15:0] hi;
    lo = 0;
    hi = 0;
    if (plat) begin
      lo = fahr ? -16'sd3000 : -16'sd2000;
      hi = fahr ? 16'sd12000 : 16'sd6500;
    end else begin
      unique case (kind)
        4'd0: begin lo = fahr ? -16'sd300 : -16'sd200; hi = fahr ? 16'sd2300 : 16'sd1300; end
        4'd1: begin lo = 0; hi = fahr ? 16'sd9000 : 16'sd5000; end
        4'd2, 4'd5: begin lo = -16'sd100; hi = fahr ? 16'sd1500 : 16'sd850; end
        4'd3, 4'd6: begin lo = 0; hi = fahr ? 16'sd7500 : 16'sd4000; end
        4'd4: begin lo = fahr ? -16'sd3000 : -16'sd2000; hi = fahr ? 16'sd7000 : 16'sd4000; end
        4'd7, 4'd8: begin lo = 0; hi = fahr ? 16'sd3000 : 16'sd1700; end
        4'd9: begin lo = fahr ? 16'sd300 : 16'sd100; hi = fahr ? 16'sd3200 : 16'sd1800; end
        default: begin lo = 0; hi = 0; end
      endcase
    end
    return upper ? 32'(hi) : 32'(lo);
  endfunction
endpackage

// file: tb/loop_setting_store_test.sv
`timescale 1ns/100ps
`default_nettype none
module loop_setting_store_test;
  import lss_pkg::*;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, onoffMode, irq, e;
  logic autoRestoreSwitch;
  logic [3:0] sensorType;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic signed [15:0] mt [LOOPS];
  logic [15:0] mc [LOOPS];
  logic [15:0] dl [LOOPS];
  logic [LOOPS-1:0] outputOn, tuningDoneFlag, heaterBreakAlarm;
  logic signed [15:0] loopSetting [LOOPS][NSET];
  lss_alarm_t alarmKindSelect [LOOPS][2];
  int numErrors, nChecks;
  lss_host_model host (.sys_clk(sys_clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  lss_loop_setting_store uut (.sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sensorPlatinum(1'b0), .sensorType(sensorType), .tempFahrenheit(1'b0),
    .autoRestoreSwitch(autoRestoreSwitch), .measuredTemperature(mt), .measuredHeaterCurrent(mc),
    .driveLevel(dl), .outputOn(outputOn), .onoffMode(onoffMode),
    .tuningDoneFlag(tuningDoneFlag), .loopSetting(loopSetting),
    .alarmKindSelect(alarmKindSelect), .heaterBreakAlarm(heaterBreakAlarm), .irq(irq));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    nChecks++;
    if (g !== x) begin
      numErrors++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic tRange;
    wr(IRQ_MASK_OFS, 32'h0000_0001);
    wr(12'h004, 32'h0000_01F5);
    chk(irq, 1'b1);
    chk(loopSetting[0][1], 32'h0000_0000);
    rd(ERR_OFS);
    chk(q, 32'h0000_0201);
    rd(IRQ_STAT_OFS);
    chk(irq, 1'b0);
    wr(12'h004, 32'h0000_01F4);
    chk(loopSetting[0][1], 32'h0000_01F4);
    wr(12'h000, 32'h0000_0515);
    chk(loopSetting[0][0], 32'h0000_0000);
    wr(12'h000, 32'h0000_0514);
    chk(loopSetting[0][0], 32'h0000_0514);
    rd(IRQ_STAT_OFS);
    $display("tRange done");
  endtask
  task automatic tAlarm;
    for (int k = 0; k < 10; k++) begin
      wr(ALARM_KIND_OFS, 32'(k * 1111));
      for (int a = 0; a < 4; a++) chk(32'(alarmKindSelect[a / 2][a % 2]), 32'(k));
    end
    wr(ALARM_KIND_OFS, 32'h0000_2710);
    rd(ERR_OFS);
    chk(q, 32'h0000_4001);
    chk(32'(alarmKindSelect[1][1]), 32'h0000_0009);
    rd(IRQ_STAT_OFS);
    $display("tAlarm done");
  endtask
  task automatic tTune;
    tuningDoneFlag <= 2'b01;
    wr(12'h024, 32'h0000_0064);
    wr(12'h064, 32'h0000_0064);
    chk(loopSetting[0][9], 32'h0000_0050);
    chk(loopSetting[1][9], 32'h0000_0064);
    tuningDoneFlag <= 2'b00;
    wr(12'h028, 32'h0000_0011);
    chk(loopSetting[0][10], 32'h0000_0011);
    $display("tTune done");
  endtask
  task automatic tMon;
    mc[0] <= 16'h0227;
    mc[1] <= 16'h0226;
    mt[1] <= 16'hFF38;
    outputOn <= 2'b01;
    onoffMode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(heaterBreakAlarm, 2'b01);
    rd(12'h0A4);
    chk(q, 32'h0000_FF38);
    rd(MON_CUR_OFS);
    chk(q, 32'h0000_CCCC);
    rd(12'h0AC);
    chk(q, 32'h0000_0226);
    rd(MON_LEVEL_OFS);
    chk(q, 32'h0000_03E8);
    rd(12'h0B4);
    chk(q, 32'h0000_0000);
    onoffMode <= 1'b0;
    // monitor is registered: let it settle before the setup-cycle capture
    repeat (2) @(posedge sys_clk);
    rd(MON_LEVEL_OFS);
    chk(q, 32'h0000_007B);
    $display("tMon done");
  endtask
  task automatic tSave;
    wr(IRQ_MASK_OFS, 32'h0000_0002);
    wr(CTRL_OFS, 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_0001);
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge sys_clk);
    chk(irq, 1'b1);
    rd(IRQ_STAT_OFS);
    chk(q, 32'h0000_0002);
    wr(CTRL_OFS, 32'h0000_0001);
    repeat (30) @(posedge sys_clk);
    chk(irq, 1'b0);
    chk(loopSetting[0][1], 32'h0000_01F4);
    $display("tSave done");
  endtask
  task automatic tBus;
    host.xfer(1'b1, 12'h0FC, 32'h0000_0001, q, e);
    chk(e, 1'b1);
    host.xfer(1'b0, 12'h0FC, 32'h0000_0000, q, e);
    chk(q, 32'h0000_0000);
    $display("tBus done");
  endtask
  // save loop 1 too, then restart with the restore switch on and a new input type
  task automatic tRestore;
    wr(CTRL_OFS, 32'h0000_0003);
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge sys_clk);
    rd(IRQ_STAT_OFS);
    chk(q, 32'h0000_0002);
    autoRestoreSwitch <= 1'b1;
    sensorType <= 4'h1;
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chk(loopSetting[0][1], 32'h0000_01F4);
    chk(loopSetting[1][9], 32'h0000_0064);
    wr(12'h000, 32'h0000_1388);
    chk(loopSetting[0][0], 32'h0000_1388);
    $display("tRestore done");
  endtask
  // ---------------------------------------------
  // clock, watchdog, main sequence
  // ---------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // whole run is a few hundred cycles
  initial begin
    #2_000_000;
    numErrors++;
    stop_test;
  end
  initial begin
    reset = 1'b1;
    mt = '{16'h0000, 16'h0000};
    mc = '{16'h0000, 16'h0000};
    dl = '{16'h007B, 16'h0000};
    outputOn = 2'b00;
    onoffMode = 1'b0;
    tuningDoneFlag = 2'b00;
    autoRestoreSwitch = 1'b0;
    sensorType = 4'h0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    tRange;
    tAlarm;
    tTune;
    tMon;
    tSave;
    tBus;
    tRestore;
    stop_test;
  end
endmodule // loop_setting_store_test
`default_nettype wire

// file: tb/lss_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lss_host_model (
  // clock
  input wire logic sys_clk,
  // apb master side
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // bus idle from time zero
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
  end
  // one transfer, entered just after a rising edge; saves stay sparse
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never lands in this time step
    @(posedge sys_clk);
  endtask
endmodule // lss_host_model
`default_nettype wire
